/* File: src/svio_device.sv */
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`include "svio_defs.svh"

// Operation
// [RULE1] accept codes 1-81, apply after power cycle
// [RULE2] outputs 3-8 default 1,2,28,16,30,31, rest 0
// [RULE3] decode basic input codes 1-11, 51-53; code 9 is not decoded
// [RULE4] decode input codes 34,35,43-50,54
// [RULE5] decode output codes 1,2,16,76,32-36
// [RULE6] output codes 60-67, 79-82 decoded; the setting check refuses code 82, so only 79-81 can reach an output
// [RULE7] ready only while servo-on held
// [RULE8] servo off: gate off, free-run, commands dropped
// [RULE9] servo off while rotating: controlled stop
// [RULE10] ready needs no alarm, servo-on, forced-stop
// [RULE11] unassigned terminal stays inactive
module svio_device (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic I_POWER_CYCLE,
  input wire logic I_ALARM,
  input wire logic [4:0] I_ALARM_CODE,
  input wire logic I_MOTOR_ROTATING,
  input wire logic I_IN_POSITION,
  input wire logic I_SERVO_CTRL_READY,
  input wire logic I_DATA_ERROR,
  input wire logic I_ADDRESS_ERROR,
  input wire logic [7:0] I_MODE,
  input wire logic I_IMM_CONT_PERMIT,
  input wire logic I_IMM_CONT_DONE,
  input wire logic I_IMM_CHANGE_DONE,
  input wire logic I_CMD_POS_DONE,
  input wire logic [1:0] I_SERVO_OFF_ACTION,
  svio_if.device LINK,
  output logic O_GATE_ENABLE,
  output logic O_FREE_RUN,
  output logic O_CONTROLLED_STOP,
  output logic [1:0] O_STOP_PROFILE,
  output logic O_READY,
  output svio_pkg::svio_in_func_type O_IN_FUNC,
  output logic [1:0] O_OUT_TERMINAL
);
  svio_pkg::svio_code_type pending_q [`SVIO_NUM_OUT];
  svio_pkg::svio_code_type active_q [`SVIO_NUM_OUT];
  svio_pkg::svio_servo_state_type state_q;
  svio_pkg::svio_servo_state_type state_d;
  svio_pkg::svio_in_func_type func_d;
  logic [15:0] out_image_q;
  logic [15:0] out_image_d;
  logic set_reject_q;
  logic [1:0] profile_q;
  logic servo_on;
  logic forced_stop_ok;
  logic free_run_req;
  logic [127:0] src_vec;

  function automatic svio_pkg::svio_code_type default_code(input int idx);
    case (idx)
      2: default_code = `SVIO_DEF_OUT3; // [RULE2]
      3: default_code = `SVIO_DEF_OUT4;
      4: default_code = `SVIO_DEF_OUT5;
      5: default_code = `SVIO_DEF_OUT6;
      6: default_code = `SVIO_DEF_OUT7;
      7: default_code = `SVIO_DEF_OUT8;
      default: default_code = `SVIO_OUT_NONE;
    endcase
  endfunction

  // settings written now sit in the pending table; only a power cycle moves them
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      for (int i = 0; i < `SVIO_NUM_OUT; i++) begin
        pending_q[i] <= default_code(i);
      end
      set_reject_q <= 1'b0;
    end else if (I_CE) begin
      set_reject_q <= 1'b0;
      if (LINK.set_valid) begin
        if (LINK.set_code == `SVIO_OUT_NONE ||
            (LINK.set_code >= `SVIO_OUT_CODE_MIN && LINK.set_code <= `SVIO_OUT_CODE_MAX)) begin
          pending_q[LINK.set_index] <= LINK.set_code; // [RULE1]
        end else begin
          set_reject_q <= 1'b1; // [RULE1]
        end
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      for (int i = 0; i < `SVIO_NUM_OUT; i++) begin
        active_q[i] <= default_code(i); // [RULE2]
      end
    end else if (I_CE && I_POWER_CYCLE) begin
      for (int i = 0; i < `SVIO_NUM_OUT; i++) begin
        active_q[i] <= pending_q[i]; // [RULE1]
      end
    end
  end

  function automatic logic img(input logic [6:0] code);
    img = LINK.in_image[code[5:0]];
  endfunction

  assign servo_on = img(`SVIO_IN_SERVO_ON);
  assign forced_stop_ok = img(`SVIO_IN_FORCED_STOP);
  assign free_run_req = img(`SVIO_IN_FREE_RUN); // [RULE4]

  // rotation commands pass only while the drive is running
  always_comb begin
    func_d = '0;
    func_d.servo_on = servo_on; // [RULE3]
    func_d.forced_stop_in = forced_stop_ok;
    func_d.home_limit_switch = img(`SVIO_IN_HOME_LIMIT);
    func_d.positive_overtravel = img(`SVIO_IN_POS_OT);
    func_d.negative_overtravel = img(`SVIO_IN_NEG_OT);
    func_d.alarm_reset = img(`SVIO_IN_ALARM_RESET);
    for (int b = 0; b < 3; b++) begin
      func_d.speed_select[b] = LINK.in_image[`SVIO_IN_SPEED_SEL0 + b]; // [RULE3]
    end
    func_d.brake_res_overheat = img(`SVIO_IN_BRAKE_RES_HOT); // [RULE4]
    func_d.teaching = img(`SVIO_IN_TEACHING);
    func_d.override_enable = img(`SVIO_IN_OVR_ENABLE);
    for (int b = 0; b < 4; b++) begin
      func_d.override_weight[b] = LINK.in_image[`SVIO_IN_OVR_W1 + b]; // [RULE4]
    end
    func_d.interrupt_enable = img(`SVIO_IN_INT_ENABLE);
    func_d.interrupt_input = img(`SVIO_IN_INT_INPUT);
    func_d.deviation_clear = img(`SVIO_IN_DEV_CLEAR);
    func_d.free_run = free_run_req;
    // servo_on gates too: state lags the image by one cycle when servo-on drops
    if (state_q == svio_pkg::SVIO_SERVO_RUN && servo_on) begin
      func_d.forward_cmd = img(`SVIO_IN_FORWARD); // [RULE8]
      func_d.reverse_cmd = img(`SVIO_IN_REVERSE);
      func_d.start_positioning = img(`SVIO_IN_START_POS);
      func_d.homing_cmd = img(`SVIO_IN_HOMING);
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      svio_pkg::SVIO_SERVO_OFF: begin
        if (servo_on && forced_stop_ok && !I_ALARM) begin
          state_d = svio_pkg::SVIO_SERVO_RUN; // [RULE10]
        end
      end
      svio_pkg::SVIO_SERVO_RUN: begin
        if (I_ALARM || !forced_stop_ok) begin
          state_d = svio_pkg::SVIO_SERVO_OFF; // [RULE10]
        end else if (!servo_on) begin
          if (I_MOTOR_ROTATING) begin
            state_d = svio_pkg::SVIO_SERVO_STOPPING; // [RULE9]
          end else begin
            state_d = svio_pkg::SVIO_SERVO_OFF; // [RULE7]
          end
        end
      end
      svio_pkg::SVIO_SERVO_STOPPING: begin
        if (!I_MOTOR_ROTATING || I_ALARM) begin
          state_d = svio_pkg::SVIO_SERVO_OFF; // [RULE9]
        end
      end
      default: state_d = svio_pkg::SVIO_SERVO_OFF;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      state_q <= svio_pkg::SVIO_SERVO_OFF;
      profile_q <= 2'h0;
    end else if (I_CE) begin
      state_q <= state_d;
      // profile frozen at entry so a mid-stop setting change cannot jerk the ramp
      if (state_q != svio_pkg::SVIO_SERVO_STOPPING) begin
        profile_q <= I_SERVO_OFF_ACTION; // [RULE9]
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      O_IN_FUNC <= '0;
    end else if (I_CE) begin
      O_IN_FUNC <= func_d;
    end
  end

  // outputs other than the stop profile derive from the state; free-run input overrides a running or stopping drive
  always_comb begin
    O_READY = (state_q == svio_pkg::SVIO_SERVO_RUN); // [RULE7]
    O_CONTROLLED_STOP = (state_q == svio_pkg::SVIO_SERVO_STOPPING); // [RULE9]
    O_GATE_ENABLE = (state_q != svio_pkg::SVIO_SERVO_OFF) && !free_run_req; // [RULE8]
    O_FREE_RUN = !O_GATE_ENABLE; // [RULE8]
    O_STOP_PROFILE = profile_q;
  end

  // bit n of src_vec is the signal of output function code n
  always_comb begin
    src_vec = '0;
    src_vec[`SVIO_OUT_READY] = O_READY; // [RULE5]
    src_vec[`SVIO_OUT_IN_POS] = I_IN_POSITION;
    src_vec[`SVIO_OUT_ALARM_NO] = I_ALARM;
    src_vec[`SVIO_OUT_ALARM_NC] = !I_ALARM;
    src_vec[`SVIO_OUT_SERVO_CTRL_RDY] = I_SERVO_CTRL_READY;
    src_vec[`SVIO_OUT_DATA_ERR] = I_DATA_ERROR;
    src_vec[`SVIO_OUT_ADDR_ERR] = I_ADDRESS_ERROR;
    src_vec[`SVIO_OUT_ALARM_CODE4:`SVIO_OUT_ALARM_CODE0] = I_ALARM_CODE; // [RULE5]
    src_vec[`SVIO_OUT_MODE_BIT7:`SVIO_OUT_MODE_BIT0] = I_MODE; // [RULE6]
    src_vec[`SVIO_OUT_IMM_CONT_PERMIT] = I_IMM_CONT_PERMIT;
    src_vec[`SVIO_OUT_IMM_CONT_DONE] = I_IMM_CONT_DONE;
    src_vec[`SVIO_OUT_IMM_CHANGE_DONE] = I_IMM_CHANGE_DONE;
    src_vec[`SVIO_OUT_CMD_POS_DONE] = I_CMD_POS_DONE; // [RULE6]
  end

  genvar g;
  generate
    for (g = 0; g < `SVIO_NUM_OUT; g++) begin : g_out
      // code 0 drives the output bit low directly instead of reading src_vec bit 0
      assign out_image_d[g] = (active_q[g] == `SVIO_OUT_NONE) ? 1'b0 : src_vec[active_q[g]]; // [RULE11]
    end
  endgenerate

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      out_image_q <= '0;
    end else if (I_CE) begin
      out_image_q <= out_image_d;
    end
  end

  assign LINK.out_image = out_image_q;
  assign LINK.set_reject = set_reject_q;
  assign O_OUT_TERMINAL = out_image_q[`SVIO_NUM_PHYS_OUT-1:0];
endmodule // svio_device

/* File: src/svio_defs.svh */
`ifndef SVIO_DEFS_SVH
`define SVIO_DEFS_SVH

// input function codes
`define SVIO_IN_SERVO_ON 7'h01
`define SVIO_IN_FORWARD 7'h02
`define SVIO_IN_REVERSE 7'h03
`define SVIO_IN_START_POS 7'h04
`define SVIO_IN_HOMING 7'h05
`define SVIO_IN_HOME_LIMIT 7'h06
`define SVIO_IN_POS_OT 7'h07
`define SVIO_IN_NEG_OT 7'h08
`define SVIO_IN_FORCED_STOP 7'h0A
`define SVIO_IN_ALARM_RESET 7'h0B
`define SVIO_IN_BRAKE_RES_HOT 7'h22
`define SVIO_IN_TEACHING 7'h23
`define SVIO_IN_OVR_ENABLE 7'h2B
`define SVIO_IN_OVR_W1 7'h2C
`define SVIO_IN_INT_ENABLE 7'h30
`define SVIO_IN_INT_INPUT 7'h31
`define SVIO_IN_DEV_CLEAR 7'h32
`define SVIO_IN_SPEED_SEL0 7'h33
`define SVIO_IN_FREE_RUN 7'h36

// output function codes
`define SVIO_OUT_NONE 7'h00
`define SVIO_OUT_READY 7'h01
`define SVIO_OUT_IN_POS 7'h02
`define SVIO_OUT_ALARM_NO 7'h10
`define SVIO_OUT_SERVO_CTRL_RDY 7'h1C
`define SVIO_OUT_DATA_ERR 7'h1E
`define SVIO_OUT_ADDR_ERR 7'h1F
`define SVIO_OUT_ALARM_CODE0 7'h20
`define SVIO_OUT_ALARM_CODE4 7'h24
`define SVIO_OUT_MODE_BIT0 7'h3C
`define SVIO_OUT_MODE_BIT7 7'h43
`define SVIO_OUT_ALARM_NC 7'h4C
`define SVIO_OUT_IMM_CONT_PERMIT 7'h4F
`define SVIO_OUT_IMM_CONT_DONE 7'h50
`define SVIO_OUT_IMM_CHANGE_DONE 7'h51
`define SVIO_OUT_CMD_POS_DONE 7'h52
`define SVIO_OUT_CODE_MIN 7'h01
`define SVIO_OUT_CODE_MAX 7'h51

// output assignment defaults, OUT3..OUT8
`define SVIO_DEF_OUT3 7'h01
`define SVIO_DEF_OUT4 7'h02
`define SVIO_DEF_OUT5 7'h1C
`define SVIO_DEF_OUT6 7'h10
`define SVIO_DEF_OUT7 7'h1E
`define SVIO_DEF_OUT8 7'h1F
`define SVIO_NUM_OUT 16
`define SVIO_NUM_PHYS_OUT 2

// host register offsets
`define SVIO_REG_IN_LO 8'h00
`define SVIO_REG_IN_HI 8'h04
`define SVIO_REG_OUT_IMAGE 8'h08
`define SVIO_REG_SETTING 8'h0C
`define SVIO_REG_INT_STATUS 8'h10
`define SVIO_REG_INT_MASK 8'h14
`define SVIO_SET_INDEX_LSB 0
`define SVIO_SET_CODE_LSB 8
`define SVIO_INT_READY_RISE 0
`define SVIO_INT_READY_FALL 1
`define SVIO_INT_SET_REJECT 2
`define SVIO_INT_OUT_CHANGE 3
`define SVIO_INT_WIDTH 4

`endif

/* File: src/svio_pkg.sv */
package svio_pkg;
  typedef enum logic [1:0] {
    SVIO_SERVO_OFF = 2'b00,
    SVIO_SERVO_RUN = 2'b01,
    SVIO_SERVO_STOPPING = 2'b10
  } svio_servo_state_type;

  typedef logic [6:0] svio_code_type;

  typedef struct packed {
    logic servo_on;
    logic forward_cmd;
    logic reverse_cmd;
    logic start_positioning;
    logic homing_cmd;
    logic home_limit_switch;
    logic positive_overtravel;
    logic negative_overtravel;
    logic forced_stop_in;
    logic alarm_reset;
    logic brake_res_overheat;
    logic teaching;
    logic override_enable;
    logic [3:0] override_weight;
    logic interrupt_enable;
    logic interrupt_input;
    logic deviation_clear;
    logic [2:0] speed_select;
    logic free_run;
  } svio_in_func_type;
endpackage

/* File: src/svio_if.sv */
`timescale 1ns/1ns
interface svio_if;
  logic [63:0] in_image;
  logic [15:0] out_image;
  logic set_valid;
  logic [3:0] set_index;
  logic [6:0] set_code;
  logic set_reject;

  modport device (
    input in_image,
    output out_image,
    input set_valid,
    input set_index,
    input set_code,
    output set_reject
  );
  modport host (
    output in_image,
    input out_image,
    output set_valid,
    output set_index,
    output set_code,
    input set_reject
  );
endinterface

/* File: src/svio_host.sv */
`timescale 1ns/1ns
`include "svio_defs.svh"

module svio_host (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic O_IRQ,
  svio_if.host LINK
);
  logic [63:0] in_image_q;
  logic [15:0] out_prev_q;
  logic [`SVIO_INT_WIDTH-1:0] int_status_q;
  logic [`SVIO_INT_WIDTH-1:0] int_mask_q;
  logic [`SVIO_INT_WIDTH-1:0] events;
  logic dp_valid_q;
  logic dp_write_q;
  logic [7:0] dp_addr_q;
  logic set_valid_q;
  logic [3:0] set_index_q;
  logic [6:0] set_code_q;
  logic wr_en;
  logic rd_status;

  // zero wait states: every access completes in its first data-phase cycle
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (I_CE && I_HREADY) begin
      dp_valid_q <= I_HSEL && I_HTRANS[1];
      dp_write_q <= I_HWRITE;
      dp_addr_q <= I_HADDR[7:0];
    end
  end

  assign wr_en = I_CE && dp_valid_q && dp_write_q;
  assign rd_status = I_CE && dp_valid_q && !dp_write_q && dp_addr_q == `SVIO_REG_INT_STATUS;

  always_comb begin
    case (dp_addr_q)
      `SVIO_REG_IN_LO: O_HRDATA = in_image_q[31:0];
      `SVIO_REG_IN_HI: O_HRDATA = in_image_q[63:32];
      `SVIO_REG_OUT_IMAGE: O_HRDATA = {16'h0000, out_prev_q};
      `SVIO_REG_INT_STATUS: O_HRDATA = {28'h0000000, int_status_q};
      `SVIO_REG_INT_MASK: O_HRDATA = {28'h0000000, int_mask_q};
      default: O_HRDATA = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      in_image_q <= 64'h0000000000000000;
      int_mask_q <= '0;
    end else if (wr_en) begin
      if (dp_addr_q == `SVIO_REG_IN_LO) in_image_q[31:0] <= I_HWDATA;
      if (dp_addr_q == `SVIO_REG_IN_HI) in_image_q[63:32] <= I_HWDATA;
      if (dp_addr_q == `SVIO_REG_INT_MASK) int_mask_q <= I_HWDATA[`SVIO_INT_WIDTH-1:0];
    end
  end

  // a setting write becomes a one-cycle request on the link
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      set_valid_q <= 1'b0;
      set_index_q <= 4'h0;
      set_code_q <= 7'h00;
    end else if (I_CE) begin
      set_valid_q <= wr_en && dp_addr_q == `SVIO_REG_SETTING;
      if (wr_en && dp_addr_q == `SVIO_REG_SETTING) begin
        set_index_q <= I_HWDATA[`SVIO_SET_INDEX_LSB +: 4];
        set_code_q <= I_HWDATA[`SVIO_SET_CODE_LSB +: 7];
      end
    end
  end

  always_comb begin
    events = '0;
    events[`SVIO_INT_READY_RISE] = LINK.out_image[2] && !out_prev_q[2];
    events[`SVIO_INT_READY_FALL] = !LINK.out_image[2] && out_prev_q[2];
    events[`SVIO_INT_SET_REJECT] = LINK.set_reject;
    events[`SVIO_INT_OUT_CHANGE] = LINK.out_image != out_prev_q;
  end

  // an event in the clearing read cycle survives the clear
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      out_prev_q <= 16'h0000;
      int_status_q <= '0;
    end else if (I_CE) begin
      out_prev_q <= LINK.out_image;
      int_status_q <= (rd_status ? '0 : int_status_q) | events;
    end
  end

  assign O_IRQ = |(int_status_q & int_mask_q);
  assign LINK.in_image = in_image_q;
  assign LINK.set_valid = set_valid_q;
  assign LINK.set_index = set_index_q;
  assign LINK.set_code = set_code_q;
endmodule // svio_host

/* File: sim/svio_sva.sv */
`timescale 1ns/1ns
module svio_sva (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic [63:0] in_image,
  input wire logic [15:0] out_image,
  input wire logic set_valid,
  input wire logic [3:0] set_index,
  input wire logic [6:0] set_code,
  input wire logic set_reject
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  logic any_set_q;
  logic out3_set_q;
  // once a setting is accepted a power cycle may re-map terminals, so the idle checks stop; the ready checks stop only once OUT3 is set
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      any_set_q <= 1'b0;
      out3_set_q <= 1'b0;
    end else if (set_valid && set_code <= 7'h51) begin
      any_set_q <= 1'b1;
      out3_set_q <= out3_set_q | (set_index == 4'h2);
    end
  end
  property p_reject;
    set_valid && set_code > 7'h51 |=> set_reject;
  endproperty
  a_reject: assert property (p_reject) else $error("bad code not refused");
  property p_accept;
    set_valid && set_code <= 7'h51 |=> !set_reject;
  endproperty
  a_accept: assert property (p_accept) else $error("good code refused");
  property p_reject_cause;
    set_reject |-> $past(set_valid) && $past(set_code) > 7'h51;
  endproperty
  a_reject_cause: assert property (p_reject_cause) else $error("refusal without cause");
  property p_idle_terms;
    !any_set_q |-> out_image[1:0] == 2'h0;
  endproperty
  a_idle_terms: assert property (p_idle_terms) else $error("unassigned terminal active");
  property p_idle_high;
    !any_set_q |-> out_image[15:8] == 8'h00;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("upper outputs not default");
  property p_ready_cause;
    !out3_set_q && out_image[2] |-> $past(in_image[1], 2) && $past(in_image[10], 2);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without enables");
  property p_servo_off;
    !out3_set_q && !in_image[1] |-> ##2 !out_image[2];
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("ready kept after servo off");
  property p_estop;
    !out3_set_q && !in_image[10] |-> ##2 !out_image[2];
  endproperty
  a_estop: assert property (p_estop) else $error("ready during forced stop");
  c_reject: cover property (set_reject);
  c_ready: cover property ($rose(out_image[2]));
  c_remap: cover property (any_set_q && out_image[0]);
endmodule // svio_sva

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pwr = 1'b0;
  logic rot = 1'b0;
  logic [1:0] act_sel = 2'h0;
  logic [31:0] st = 32'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hrdata, r, seed = 32'h5526;
  logic ce = 1'b1;
  logic hready, hresp, irq, gate, free, cstop, rdy;
  logic [1:0] prof, oterm;
  logic [63:0] img = 64'h0;
  svio_pkg::svio_in_func_type ifunc, ef;
  int n_errors = 0;
  int check_count = 0;
  int pend[16];
  int actv[16];
  svio_if link();
  svio_device i_svio_device (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce),
    .I_POWER_CYCLE(pwr), .I_ALARM(st[0]), .I_ALARM_CODE(st[5:1]), .I_MOTOR_ROTATING(rot),
    .I_IN_POSITION(st[6]), .I_SERVO_CTRL_READY(st[7]), .I_DATA_ERROR(st[8]),
    .I_ADDRESS_ERROR(st[9]), .I_MODE(st[17:10]), .I_IMM_CONT_PERMIT(st[18]),
    .I_IMM_CONT_DONE(st[19]), .I_IMM_CHANGE_DONE(st[20]), .I_CMD_POS_DONE(st[21]),
    .I_SERVO_OFF_ACTION(act_sel), .LINK(link), .O_GATE_ENABLE(gate), .O_FREE_RUN(free),
    .O_CONTROLLED_STOP(cstop), .O_STOP_PROFILE(prof), .O_READY(rdy), .O_IN_FUNC(ifunc),
    .O_OUT_TERMINAL(oterm));
  svio_host i_svio_host (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_HSEL(1'b1),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_IRQ(irq),
    .LINK(link));
  svio_sva i_svio_sva (.I_REF_CLK(clk), .I_RESET_N(rst_n), .in_image(link.in_image),
    .out_image(link.out_image), .set_valid(link.set_valid), .set_index(link.set_index),
    .set_code(link.set_code), .set_reject(link.set_reject));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic setimg(input logic [63:0] v);
    img = v;
    bus(1'b1, 32'h0, v[31:0]);
    bus(1'b1, 32'h4, v[63:32]);
    repeat (4) @(posedge clk);
  endtask
  task automatic assign_out(input int k, input int c);
    bus(1'b1, 32'hC, {17'h0, 7'(c), 4'h0, 4'(k)});
    if (c <= 81) pend[k] = c;
    repeat (5) @(posedge clk);
  endtask
  function automatic logic fo(input int c, input logic rd1);
    if (c == 1) return rd1;
    if (c == 2) return st[6];
    if (c == 16) return st[0];
    if (c == 76) return !st[0];
    if (c == 28) return st[7];
    if (c == 30 || c == 31) return st[c-22];
    if (c >= 32 && c <= 36) return st[c-31];
    if (c >= 60 && c <= 67) return st[c-50];
    if (c >= 79) return st[c-61];
    return 1'b0;
  endfunction
  task automatic check_all();
    logic erdy;
    logic [15:0] e;
    erdy = img[1] & img[10] & !st[0];
    for (int k = 0; k < 16; k++) e[k] = fo(actv[k], erdy);
    ef = {img[1], img[2] & erdy, img[3] & erdy, img[4] & erdy, img[5] & erdy, img[6], img[7],
      img[8], img[10], img[11], img[34], img[35], img[43], img[47:44], img[48], img[49],
      img[50], img[53:51], img[54]};
    bus(1'b0, 32'h8, 32'h0);
    chk(r[15:0], e);
    chk(oterm, e[1:0]);
    chk(rdy, erdy);
    chk(gate, erdy & !img[54]);
    chk(free, !(erdy & !img[54]));
    chk(ifunc, ef);
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // long enough for every sequence below with wide margin
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
  initial begin
    foreach (pend[k]) pend[k] = 0;
    pend[2] = 1;
    pend[3] = 2;
    pend[4] = 28;
    pend[5] = 16;
    pend[6] = 30;
    pend[7] = 31;
    actv = pend;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_all();
    repeat (12) begin
      st <= rnd();
      setimg({rnd(), rnd() | (rnd() & 32'h402)});
      check_all();
    end
    for (int c = 0; c <= 84; c++) begin
      assign_out(0, c);
      assign_out(1, 84 - c);
      // not applied before the power cycle
      check_all();
      pwr <= 1'b1;
      @(posedge clk);
      pwr <= 1'b0;
      actv = pend;
      st <= rnd();
      setimg({rnd(), rnd() | (rnd() & 32'h402)});
      check_all();
    end
    st <= 32'h0;
    for (int a = 0; a < 4; a++) begin
      act_sel <= 2'(a);
      setimg(64'h402);
      chk(rdy, 1'b1);
      rot <= 1'b1;
      setimg(64'h400);
      chk({cstop, prof, gate}, {1'b1, 2'(a), 1'b1});
      rot <= 1'b0;
      repeat (3) @(posedge clk);
      chk({cstop, free, rdy}, 3'h2);
    end
    // clock enable low must freeze the servo state against a new alarm
    setimg(64'h402);
    ce <= 1'b0;
    st <= 32'h1;
    repeat (3) @(posedge clk);
    chk(rdy, 1'b1);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk(rdy, 1'b0);
    st <= 32'h0;
    bus(1'b0, 32'h10, 32'h0);
    assign_out(3, 127);
    chk(irq, 1'b0);
    chk(hresp, 1'b0);
    bus(1'b0, 32'h10, 32'h0);
    chk(r[2], 1'b1);
    bus(1'b1, 32'h14, 32'h4);
    bus(1'b0, 32'h10, 32'h0);
    chk(r[2], 1'b0);
    assign_out(3, 82);
    chk(irq, 1'b1);
    bus(1'b0, 32'h10, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b1, 32'h18, 32'hFFFFFFFF);
    bus(1'b0, 32'h18, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, img[31:0]);
    end_sim();
  end
endmodule // tb_top
